// ==== vfd_pkg.sv ====
`default_nettype none
package vfd_pkg;

  // packet and slot geometry
  localparam int SLOTS     = 8;
  localparam int INSN_W    = 32;
  localparam int PKT_W     = SLOTS * INSN_W;
  localparam int UNITS     = 8;
  localparam int NREG      = 16;
  localparam int REG_AW    = 4;
  localparam int PTR_W     = 3;
  localparam int RD_PER_U  = 3;
  localparam int RF_RD     = UNITS * RD_PER_U;
  localparam int RF_WR     = UNITS * 2;
  localparam int SIDES     = 2;

  localparam logic [31:0] RESET_PC = 32'h0000_0000;
  localparam logic [31:0] PKT_STEP = 32'h0000_0020;

  // instruction fields
  localparam int CHAIN_BIT = 0;
  localparam int SIDE_BIT  = 1;
  localparam int UNIT_LSB  = 2;
  localparam int UNIT_W    = 3;
  localparam int CLASS_LSB = 5;
  localparam int CLASS_W   = 3;
  localparam int SIZE_LSB  = 8;
  localparam int CIRC_BIT  = 10;
  localparam int LONG_BIT  = 11;
  localparam int SRC1_LSB  = 12;
  localparam int SRC2_LSB  = 16;
  localparam int DST_LSB   = 20;
  localparam int XOFF_LSB  = 24;
  localparam int Z_BIT     = 28;
  localparam int CREG_LSB  = 29;
  localparam int CREG_W    = 3;
  localparam int OFF_W     = 15;
  localparam int CIRC_BITS = 8;

  // unit ids: bit 2 picks the side
  localparam logic [UNIT_W-1:0] LOGIC_UNIT_SIDE_A   = 3'h0;
  localparam logic [UNIT_W-1:0] SHIFT_UNIT_SIDE_A   = 3'h1;
  localparam logic [UNIT_W-1:0] MULTIPLIER_SIDE_A   = 3'h2;
  localparam logic [UNIT_W-1:0] ADDRESS_UNIT_SIDE_A = 3'h3;
  localparam logic [UNIT_W-1:0] LOGIC_UNIT_SIDE_B   = 3'h4;
  localparam logic [UNIT_W-1:0] SHIFT_UNIT_SIDE_B   = 3'h5;
  localparam logic [UNIT_W-1:0] MULTIPLIER_SIDE_B   = 3'h6;
  localparam logic [UNIT_W-1:0] ADDRESS_UNIT_SIDE_B = 3'h7;
  localparam logic [1:0]        KIND_SHIFT          = 2'h1;
  localparam logic [1:0]        KIND_MULT           = 2'h2;
  localparam logic [1:0]        KIND_ADDR           = 2'h3;

  // operation classes
  localparam logic [CLASS_W-1:0] CLS_ALU             = 3'h0;
  localparam logic [CLASS_W-1:0] CLS_MUL             = 3'h1;
  localparam logic [CLASS_W-1:0] DOUBLE_WORD_LOAD_OP = 3'h2;
  localparam logic [CLASS_W-1:0] CLS_LOAD            = 3'h3;
  localparam logic [CLASS_W-1:0] CLS_STORE           = 3'h4;

  localparam logic [1:0]        SZ_WORD       = 2'h2;
  localparam logic [REG_AW-1:0] LONG_BASE_REG = 4'hE;
  localparam logic [CREG_W-1:0] CREG_ALWAYS   = 3'h0;

  typedef struct packed {
    logic              valid;
    logic              exec;
    logic [INSN_W-1:0] insn;
    logic [INSN_W-1:0] op_a;
    logic [INSN_W-1:0] op_b;
  } vfd_issue_t;

  typedef struct packed {
    logic              valid;
    logic              store;
    logic              data_side;
    logic [REG_AW-1:0] data_reg;
    logic [1:0]        size;
    logic [31:0]       addr;
  } vfd_mem_t;

  typedef struct packed {
    logic              valid;
    logic              dw;
    logic              side;
    logic [REG_AW-1:0] dst;
    logic [63:0]       data;
  } vfd_result_t;

  typedef struct packed {
    logic unit_conflict;
    logic cross_read_drop;
    logic cross_write_drop;
    logic route_err;
    logic span_err;
  } vfd_flags_t;

  function automatic logic [UNIT_W-1:0] vfd_unit_of(input logic [INSN_W-1:0] insn);
    return insn[UNIT_LSB +: UNIT_W];
  endfunction : vfd_unit_of

  function automatic logic [CLASS_W-1:0] vfd_class_of(input logic [INSN_W-1:0] insn);
    return insn[CLASS_LSB +: CLASS_W];
  endfunction : vfd_class_of

  // long form: fixed base, word size, linear only
  function automatic logic [OFF_W-1:0] vfd_offset_of(input logic [INSN_W-1:0] insn);
    if (insn[LONG_BIT]) begin
      return {insn[XOFF_LSB +: 4], insn[SRC1_LSB +: 8], insn[SIZE_LSB +: 3]};
    end
    return {10'h000, insn[XOFF_LSB], insn[SRC2_LSB +: 4]};
  endfunction : vfd_offset_of

endpackage : vfd_pkg
`default_nettype wire

// ==== vfd_regfile.sv ====
`timescale 1ns/1ns
`default_nettype none
module vfd_regfile
  import vfd_pkg::*;
(
  // clock and reset
  input  wire logic                           ref_clk_in,
  input  wire logic                           rstn_in,
  input  wire logic                           ce_in,
  // write ports, higher index wins
  input  wire logic [RF_WR-1:0]               wr_en_in,
  input  wire logic [RF_WR-1:0][REG_AW-1:0]   wr_addr_in,
  input  wire logic [RF_WR-1:0][INSN_W-1:0]   wr_data_in,
  // read ports
  input  wire logic [RF_RD-1:0][REG_AW-1:0]   rd_addr_in,
  output logic      [RF_RD-1:0][INSN_W-1:0]   rd_data_out
);

  logic [INSN_W-1:0] mem_reg [NREG];

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int r = 0; r < NREG; r++) begin
        mem_reg[r] <= 32'h0000_0000;
      end
    end else if (ce_in) begin
      for (int w = 0; w < RF_WR; w++) begin
        if (wr_en_in[w]) begin
          mem_reg[wr_addr_in[w]] <= wr_data_in[w];
        end
      end
    end
  end

  // every unit of the side reads in the same cycle
  for (genvar g = 0; g < RF_RD; g++) begin : g_rd
    assign rd_data_out[g] = mem_reg[rd_addr_in[g]];
  end

endmodule : vfd_regfile
`default_nettype wire

// ==== vfd_core.sv ====
`timescale 1ns/1ns
`default_nettype none
// How it works
// - fetch always takes a whole 256-bit packet of eight 32-bit slots
// - bit 0 set chains the next slot into the same parallel group
// - bit 0 clear ends the group; next slot issues next cycle
// - groups hold one to eight slots, packets one to eight groups
// - at most one parallel group issues per clock; none while a packet is fetched
// - next packet is requested on the same edge its last group issues
// - units without an instruction this cycle stay idle
// - two register sides, sixteen 32-bit registers each, four units per side
// - a side's file serves all four local units in one cycle
// - one cross read and one cross write per side per cycle
// - shift units do double-word loads, 64 bits per side
// - multiplies go only to the two multiplier units
// - address units do linear or circular addressing, 5 or 15-bit offsets
// - address from one side may load or store the other side
// - every instruction conditional; false condition suppresses it
// - loads and stores of byte, half and word at byte addresses
module vfd_core
  import vfd_pkg::*;
(
  // clock, reset, enable
  input  wire logic                     ref_clk_in,
  input  wire logic                     rstn_in,
  input  wire logic                     ce_in,
  // program memory
  output logic                          fetch_req_out,
  output logic [31:0]                   fetch_addr_out,
  input  wire logic                     fetch_valid_in,
  input  wire logic [PKT_W-1:0]         fetch_data_in,
  // functional units
  output vfd_issue_t [UNITS-1:0]        issue_out,
  output vfd_mem_t   [SIDES-1:0]        mem_out,
  input  wire vfd_result_t [UNITS-1:0]  result_in,
  // status pulses
  output vfd_flags_t                    flags_out
);

  typedef enum logic {ST_REQ, ST_RUN} vfd_state_t;

  vfd_state_t                      state_reg;
  vfd_state_t                      state_next;
  logic                            fetch_req_reg;
  logic [31:0]                     fetch_addr_reg;
  logic [PKT_W-1:0]                pkt_reg;
  logic [PTR_W-1:0]                ptr_reg;
  vfd_issue_t [UNITS-1:0]          issue_reg;
  vfd_issue_t [UNITS-1:0]          issue_next;
  vfd_mem_t   [SIDES-1:0]          mem_reg;
  vfd_mem_t   [SIDES-1:0]          mem_next;
  vfd_flags_t                      flags_reg;
  vfd_flags_t                      flags_next;

  logic [INSN_W-1:0]               slot    [SLOTS];
  logic [PTR_W-1:0]                grp_end;
  logic                            grp_closed;
  logic                            accept;
  logic                            grp_last;
  logic [UNITS-1:0]                sel_valid;
  logic [INSN_W-1:0]               sel_insn [UNITS];
  logic [RF_RD-1:0][REG_AW-1:0]    rd_addr;
  logic [RF_RD-1:0][INSN_W-1:0]    rd_data [SIDES];
  logic [RF_WR-1:0]                wr_en   [SIDES];
  logic [RF_WR-1:0][REG_AW-1:0]    wr_addr [SIDES];
  logic [RF_WR-1:0][INSN_W-1:0]    wr_data [SIDES];
  logic                            cross_wr_drop;
  logic                            unit_clash;

  assign accept   = (state_reg == ST_REQ) && fetch_req_reg && fetch_valid_in;
  assign grp_last = (state_reg == ST_RUN) && (grp_end == PTR_W'(SLOTS - 1));

  // group boundary: first unchained slot at or after the pointer
  always_comb begin
    grp_end    = PTR_W'(SLOTS - 1);
    grp_closed = 1'b0;
    for (int i = 0; i < SLOTS; i++) begin
      slot[i] = pkt_reg[i * INSN_W +: INSN_W];
      if (!grp_closed && i >= int'(ptr_reg) && !slot[i][CHAIN_BIT]) begin
        grp_end    = PTR_W'(i);
        grp_closed = 1'b1;
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_REQ: begin
        if (accept) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (grp_last) begin
          state_next = ST_REQ;
        end
      end
      default: state_next = ST_REQ;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= ST_REQ;
    end else if (ce_in) begin
      state_reg <= state_next;
    end
  end

  // request drops the cycle the packet is taken
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fetch_req_reg  <= 1'b0;
      fetch_addr_reg <= RESET_PC;
    end else if (ce_in) begin
      fetch_req_reg <= (state_next == ST_REQ);
      if (accept) begin
        fetch_addr_reg <= fetch_addr_reg + PKT_STEP;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pkt_reg <= '0;
      ptr_reg <= '0;
    end else if (ce_in) begin
      if (accept) begin
        pkt_reg <= fetch_data_in;
        ptr_reg <= '0;
      end else if (state_reg == ST_RUN && !grp_last) begin
        ptr_reg <= grp_end + PTR_W'(1);
      end
    end
  end

  // route slots of the current group to their units
  always_comb begin
    unit_clash = 1'b0;
    for (int u = 0; u < UNITS; u++) begin
      sel_valid[u] = 1'b0;
      sel_insn[u]  = '0;
      for (int i = 0; i < SLOTS; i++) begin
        if (state_reg == ST_RUN && i >= int'(ptr_reg) && i <= int'(grp_end)
            && vfd_unit_of(slot[i]) == UNIT_W'(u)) begin
          if (sel_valid[u]) begin
            unit_clash = 1'b1;
          end else begin
            sel_valid[u] = 1'b1;
            sel_insn[u]  = slot[i];
          end
        end
      end
      // ports: base or src1, src2 or data register, condition register
      rd_addr[u * RD_PER_U]     = (sel_insn[u][LONG_BIT] && u[1:0] == KIND_ADDR)
                                  ? LONG_BASE_REG : sel_insn[u][SRC1_LSB +: REG_AW];
      rd_addr[u * RD_PER_U + 1] = (u[1:0] == KIND_ADDR) ? sel_insn[u][DST_LSB +: REG_AW]
                                                        : sel_insn[u][SRC2_LSB +: REG_AW];
      rd_addr[u * RD_PER_U + 2] = {2'h0, sel_insn[u][CREG_LSB +: 2]};
    end
  end

  // operands, condition, cross-path limit and address generation
  always_comb begin
    logic [SIDES-1:0]  xrd_used;
    logic              u_side;
    logic              b_side;
    logic              drop;
    logic              cond_ok;
    logic [31:0]       cond_val;
    logic [CLASS_W-1:0] cls;
    logic [1:0]        kind;
    logic [1:0]        size;
    logic [31:0]       sum;
    xrd_used = '0;
    u_side   = 1'b0;
    b_side   = 1'b0;
    drop     = 1'b0;
    cond_ok  = 1'b0;
    cond_val = '0;
    cls      = '0;
    kind     = '0;
    size     = '0;
    sum      = '0;
    issue_next              = '0;
    mem_next                = '0;
    // one process owns the whole flag word
    flags_next                  = '0;
    flags_next.unit_conflict    = unit_clash;
    flags_next.cross_write_drop = cross_wr_drop;
    flags_next.span_err         = (state_reg == ST_RUN) && !grp_closed;
    for (int u = 0; u < UNITS; u++) begin
      u_side = u[2];
      kind   = u[1:0];
      cls    = vfd_class_of(sel_insn[u]);
      drop   = 1'b0;
      b_side = (kind == KIND_ADDR) ? sel_insn[u][SIDE_BIT]
                                   : (u_side ^ sel_insn[u][SIDE_BIT]);
      if (sel_valid[u] && kind != KIND_ADDR && sel_insn[u][SIDE_BIT]) begin
        if (xrd_used[u_side]) begin
          drop                       = 1'b1;
          flags_next.cross_read_drop = 1'b1;
        end
        xrd_used[u_side] = 1'b1;
      end
      if (sel_valid[u] && ((cls == CLS_MUL && kind != KIND_MULT)
          || (cls == DOUBLE_WORD_LOAD_OP && kind != KIND_SHIFT)
          || ((cls == CLS_LOAD || cls == CLS_STORE) && kind != KIND_ADDR))) begin
        drop                 = 1'b1;
        flags_next.route_err = 1'b1;
      end
      cond_val = rd_data[sel_insn[u][CREG_LSB + 2]][u * RD_PER_U + 2];
      cond_ok  = (sel_insn[u][CREG_LSB +: CREG_W] == CREG_ALWAYS)
                 || (sel_insn[u][Z_BIT] == (cond_val == 32'h0000_0000));
      issue_next[u].valid = sel_valid[u];
      issue_next[u].exec  = sel_valid[u] && cond_ok && !drop;
      issue_next[u].insn  = sel_insn[u];
      issue_next[u].op_a  = rd_data[u_side][u * RD_PER_U];
      issue_next[u].op_b  = rd_data[b_side][u * RD_PER_U + 1];
      if (kind == KIND_ADDR) begin
        size = sel_insn[u][LONG_BIT] ? SZ_WORD : sel_insn[u][SIZE_LSB +: 2];
        sum  = issue_next[u].op_a
               + ({17'h00000, vfd_offset_of(sel_insn[u])} << size);
        mem_next[u_side].valid     = issue_next[u].exec
                                     && (cls == CLS_LOAD || cls == CLS_STORE);
        mem_next[u_side].store     = (cls == CLS_STORE);
        mem_next[u_side].data_side = sel_insn[u][SIDE_BIT];
        mem_next[u_side].data_reg  = sel_insn[u][DST_LSB +: REG_AW];
        mem_next[u_side].size      = size;
        // circular keeps the block, only the low bits wrap
        mem_next[u_side].addr      = (sel_insn[u][CIRC_BIT] && !sel_insn[u][LONG_BIT])
                                     ? {issue_next[u].op_a[31:CIRC_BITS], sum[CIRC_BITS-1:0]}
                                     : sum;
      end
    end
  end

  // results: local writes free, one cross write per target side
  always_comb begin
    logic [SIDES-1:0] xwr_used;
    logic             t;
    logic             ok;
    xwr_used      = '0;
    t             = 1'b0;
    ok            = 1'b0;
    cross_wr_drop = 1'b0;
    for (int s = 0; s < SIDES; s++) begin
      wr_en[s]   = '0;
      wr_addr[s] = '0;
      wr_data[s] = '0;
    end
    for (int u = 0; u < UNITS; u++) begin
      t  = result_in[u].side;
      ok = result_in[u].valid;
      if (ok && t != u[2]) begin
        if (xwr_used[t]) begin
          ok            = 1'b0;
          cross_wr_drop = 1'b1;
        end
        xwr_used[t] = 1'b1;
      end
      if (ok && result_in[u].dw && u[1:0] != KIND_SHIFT) begin
        ok = 1'b0;
      end
      if (ok) begin
        wr_en[t][2 * u]   = 1'b1;
        wr_addr[t][2 * u] = result_in[u].dw ? {result_in[u].dst[REG_AW-1:1], 1'b0}
                                            : result_in[u].dst;
        wr_data[t][2 * u] = result_in[u].data[31:0];
        if (result_in[u].dw) begin
          wr_en[t][2 * u + 1]   = 1'b1;
          wr_addr[t][2 * u + 1] = {result_in[u].dst[REG_AW-1:1], 1'b1};
          wr_data[t][2 * u + 1] = result_in[u].data[63:32];
        end
      end
    end
  end

  for (genvar s = 0; s < SIDES; s++) begin : g_side
    vfd_regfile u_rf (
      .ref_clk_in  (ref_clk_in),
      .rstn_in     (rstn_in),
      .ce_in       (ce_in),
      .wr_en_in    (wr_en[s]),
      .wr_addr_in  (wr_addr[s]),
      .wr_data_in  (wr_data[s]),
      .rd_addr_in  (rd_addr),
      .rd_data_out (rd_data[s])
    );
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      issue_reg <= '0;
      mem_reg   <= '0;
      flags_reg <= '0;
    end else if (ce_in) begin
      issue_reg <= issue_next;
      mem_reg   <= mem_next;
      flags_reg <= flags_next;
    end
  end

  assign fetch_req_out  = fetch_req_reg;
  assign fetch_addr_out = fetch_addr_reg;
  assign issue_out      = issue_reg;
  assign mem_out        = mem_reg;
  assign flags_out      = flags_reg;

endmodule : vfd_core
`default_nettype wire

// ==== vfd_core_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module vfd_core_monitor
  import vfd_pkg::*;
(
  // clock and reset
  input wire logic                    ref_clk_in,
  input wire logic                    rstn_in,
  input wire logic                    ce_in,
  // program memory
  input wire logic                    fetch_req_out,
  input wire logic [31:0]             fetch_addr_out,
  input wire logic                    fetch_valid_in,
  input wire logic [PKT_W-1:0]        fetch_data_in,
  // functional units
  input wire vfd_issue_t [UNITS-1:0]  issue_out,
  input wire vfd_mem_t [SIDES-1:0]    mem_out,
  input wire vfd_result_t [UNITS-1:0] result_in,
  input wire vfd_flags_t              flags_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  logic [UNITS-1:0] val_w;
  logic [UNITS-1:0] exe_w;
  logic [UNITS-1:0] mul_w;
  logic [UNITS-1:0] dw_w;
  logic             take_w;
  logic [31:0]      last_addr_reg;
  logic             seen_reg;

  always_comb begin
    for (int u = 0; u < UNITS; u++) begin
      val_w[u] = issue_out[u].valid;
      exe_w[u] = issue_out[u].exec;
      mul_w[u] = exe_w[u] && (issue_out[u].insn[CLASS_LSB +: CLASS_W] == CLS_MUL);
      dw_w[u]  = exe_w[u] && (issue_out[u].insn[CLASS_LSB +: CLASS_W] == DOUBLE_WORD_LOAD_OP);
    end
  end

  assign take_w = ce_in && fetch_req_out && fetch_valid_in;

  // remembers the last taken address; first request after reset has none
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      last_addr_reg <= 32'h0000_0000;
      seen_reg      <= 1'b0;
    end else if (take_w) begin
      last_addr_reg <= fetch_addr_out;
      seen_reg      <= 1'b1;
    end
  end

  AST_REQ_HOLD:
  assert property (fetch_req_out && !fetch_valid_in && ce_in |=>
    fetch_req_out && $stable(fetch_addr_out)) else $error("fetch request not held");
  AST_REQ_DROP:
  assert property (take_w |=> !fetch_req_out) else $error("request stays after take");
  AST_ADDR_STEP:
  assert property ($rose(fetch_req_out) && seen_reg |->
    fetch_addr_out == last_addr_reg + PKT_STEP) else $error("packet address step wrong");
  AST_IDLE_WAIT:
  assert property (ce_in && fetch_req_out && $past(fetch_req_out) |-> val_w == '0)
    else $error("issue while waiting for packet");
  AST_FIRST_GROUP:
  assert property (take_w ##1 ce_in |=> val_w != '0) else $error("first group late");
  AST_EXEC_VALID:
  assert property ((exe_w & ~val_w) == '0) else $error("idle unit executes");
  AST_MUL_UNIT:
  assert property ((mul_w & 8'hBB) == '0) else $error("multiply off multiplier");
  AST_DW_UNIT:
  assert property ((dw_w & 8'hDD) == '0) else $error("double load off shift unit");
  AST_MEM_UNIT:
  assert property (!(mem_out[0].valid && !exe_w[3]) && !(mem_out[1].valid && !exe_w[7]))
    else $error("memory access without address unit");
  AST_ROUTE_FLAG:
  assert property (flags_out.route_err |-> (val_w & ~exe_w) != '0)
    else $error("route error without drop");
  AST_CROSS_FLAG:
  assert property (flags_out.cross_read_drop |-> (val_w & ~exe_w) != '0)
    else $error("cross read flag without drop");
endmodule : vfd_core_monitor

bind vfd_core vfd_core_monitor i_vfd_core_monitor (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
  .fetch_req_out(fetch_req_out), .fetch_addr_out(fetch_addr_out),
  .fetch_valid_in(fetch_valid_in), .fetch_data_in(fetch_data_in),
  .issue_out(issue_out), .mem_out(mem_out), .result_in(result_in), .flags_out(flags_out)
);
`default_nettype wire

// ==== vfd_prog_mem.sv ====
`timescale 1ns/1ns
`default_nettype none
module vfd_prog_mem
  import vfd_pkg::*;
(
  // clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             rstn_in,
  // pacing
  input  wire logic             slow_in,
  // fetch side
  input  wire logic             fetch_req_in,
  input  wire logic [31:0]      fetch_addr_in,
  output logic                  fetch_valid_out,
  output logic [PKT_W-1:0]      fetch_data_out
);
  logic [PKT_W-1:0] mem [0:7];
  logic [1:0]       wait_reg;

  // data toggles whenever not valid, so a stale packet is never mistaken
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fetch_valid_out <= 1'b0;
      fetch_data_out  <= '0;
      wait_reg        <= 2'h0;
    end else if (fetch_valid_out && fetch_req_in) begin
      fetch_valid_out <= 1'b0;
      fetch_data_out  <= ~fetch_data_out;
    end else if (fetch_req_in && !fetch_valid_out) begin
      if (!slow_in || wait_reg == 2'h3) begin
        fetch_valid_out <= 1'b1;
        fetch_data_out  <= mem[fetch_addr_in[7:5]];
        wait_reg        <= 2'h0;
      end else begin
        wait_reg       <= wait_reg + 2'h1;
        fetch_data_out <= ~fetch_data_out;
      end
    end else if (!fetch_valid_out) begin
      fetch_data_out <= ~fetch_data_out;
    end
  end
endmodule : vfd_prog_mem
`default_nettype wire

// ==== vliw_fetch_dispatch_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module vliw_fetch_dispatch_tb
  import vfd_pkg::*;
;
  logic                    ref_clk_in = 1'b0;
  logic                    rstn_in = 1'b0;
  logic                    ce_in = 1'b1;
  logic                    slow = 1'b0;
  logic                    req;
  logic                    valid;
  logic [31:0]             addr;
  logic [PKT_W-1:0]        pkt;
  vfd_issue_t [UNITS-1:0]  iss;
  vfd_mem_t [SIDES-1:0]    mo;
  vfd_result_t [UNITS-1:0] res = '0;
  vfd_flags_t              flg;
  int                      failures = 0;
  int                      comparisons = 0;
  int                      cyc = 0;
  int                      pcyc = 0;
  logic [2:0]              kc [4] = '{CLS_ALU, DOUBLE_WORD_LOAD_OP, CLS_MUL, CLS_LOAD};

  always #20 ref_clk_in = ~ref_clk_in;

  vfd_core i_vfd_core (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .fetch_req_out(req), .fetch_addr_out(addr), .fetch_valid_in(valid),
    .fetch_data_in(pkt), .issue_out(iss), .mem_out(mo), .result_in(res), .flags_out(flg)
  );
  vfd_prog_mem i_vfd_prog_mem (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .slow_in(slow), .fetch_req_in(req),
    .fetch_addr_in(addr), .fetch_valid_out(valid), .fetch_data_out(pkt)
  );

  task automatic report_and_stop();
    if (failures == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  // under a hundred cycles are needed; far more means a hang
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [7:0] mask(input logic ex);
    logic [7:0] m;
    for (int u = 0; u < UNITS; u++) begin
      m[u] = ex ? iss[u].exec : iss[u].valid;
    end
    return m;
  endfunction : mask

  function automatic logic [31:0] mk(input logic [2:0] u, input logic [2:0] c, input logic ch);
    return (32'(c) << CLASS_LSB) | (32'(u) << UNIT_LSB) | 32'(ch);
  endfunction : mk

  task automatic put(input int k, input int s, input logic [31:0] w);
    i_vfd_prog_mem.mem[k][32*s +: 32] = w;
  endtask : put

  // waits for the next group, bounded, then judges units, conditions and flags
  task automatic grp(input logic [7:0] vm, input logic [7:0] em, input logic [4:0] fl,
                     input logic btb);
    int n;
    n = 0;
    @(negedge ref_clk_in);
    while (mask(1'b0) === 8'h00 && n < 60) begin
      @(negedge ref_clk_in);
      n++;
    end
    check(64'(mask(1'b0)), 64'(vm));
    check(64'(mask(1'b1)), 64'(em));
    check(64'(flg), 64'(fl));
    if (btb) begin
      check(64'(cyc), 64'(pcyc + 1));
    end
    pcyc = cyc;
  endtask : grp

  // unused slots stay zero: single always-true logic-unit groups as padding
  task automatic load_pkts();
    for (int k = 0; k < 8; k++) begin
      i_vfd_prog_mem.mem[k] = '0;
    end
    put(0, 0, mk(3'h0, CLS_ALU, 1'b1));
    put(0, 1, mk(3'h4, CLS_ALU, 1'b0));
    put(0, 2, mk(3'h3, CLS_LOAD, 1'b0) | 32'h0000_0200);
    for (int i = 0; i < 8; i++) begin
      put(1, i, mk(3'(i), kc[i % 4], i < 7));
    end
    put(2, 0, mk(3'h0, CLS_MUL, 1'b0));
    put(2, 1, mk(3'h1, CLS_ALU, 1'b1));
    put(2, 2, mk(3'h1, CLS_ALU, 1'b0));
    put(2, 3, 32'h2000_0000);
    put(2, 4, 32'h3000_0000);
    put(2, 5, mk(3'h0, CLS_ALU, 1'b1) | 32'h0000_0002);
    put(2, 6, mk(3'h1, CLS_ALU, 1'b0) | 32'h0000_0002);
    put(3, 0, mk(3'h3, CLS_LOAD, 1'b0) | 32'h0005_0000);
    put(3, 1, mk(3'h3, CLS_LOAD, 1'b0) | 32'h0005_0102);
    put(3, 2, mk(3'h3, CLS_STORE, 1'b0) | 32'h0005_0200);
    put(3, 3, mk(3'h3, CLS_LOAD, 1'b0) | 32'h0000_1800);
    put(3, 4, mk(3'h3, CLS_LOAD, 1'b0) | 32'h010F_0600);
    put(3, 5, mk(3'h7, CLS_LOAD, 1'b0) | 32'h0001_0200);
    put(4, 0, 32'h0005_4000);
    put(4, 1, 32'h0007_6000);
  endtask : load_pkts

  task automatic sc_results();
    int n;
    n = 0;
    @(posedge ref_clk_in);
    res[1] <= '{1'b1, 1'b1, 1'b0, 4'h4, 64'hCAFE_0002_BEEF_0001};
    res[4] <= '{1'b1, 1'b0, 1'b0, 4'h6, 64'h0000_0000_0000_0011};
    res[5] <= '{1'b1, 1'b0, 1'b0, 4'h7, 64'h0000_0000_0000_0022};
    @(posedge ref_clk_in);
    res <= '0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (flg.cross_write_drop !== 1'b1 && n < 4);
    check(64'(flg.cross_write_drop), 64'h1);
  endtask : sc_results

  task automatic sc_chain();
    grp(8'h11, 8'h11, 5'h00, 1'b0);
    grp(8'h08, 8'h08, 5'h00, 1'b1);
    check(64'(mo[0].valid), 64'h1);
    for (int g = 0; g < 5; g++) begin
      check(64'(req), 64'h0);
      grp(8'h01, 8'h01, 5'h00, 1'b1);
    end
    check(64'(req), 64'h1);
  endtask : sc_chain

  task automatic sc_wide();
    grp(8'hFF, 8'hFF, 5'h00, 1'b0);
    check(64'({mo[1].valid, mo[0].valid}), 64'h3);
  endtask : sc_wide

  task automatic sc_refuse();
    @(posedge ref_clk_in);
    slow <= 1'b1;
    grp(8'h01, 8'h00, 5'h02, 1'b0);
    grp(8'h02, 8'h02, 5'h10, 1'b1);
    grp(8'h01, 8'h00, 5'h00, 1'b1);
    grp(8'h01, 8'h01, 5'h00, 1'b1);
    grp(8'h03, 8'h01, 5'h08, 1'b1);
    grp(8'h01, 8'h01, 5'h00, 1'b1);
  endtask : sc_refuse

  // f packs store, data side and size
  task automatic am(input int s, input logic [3:0] f, input logic [31:0] a,
                    input logic [7:0] vm, input logic btb);
    logic [36:0] got;
    grp(vm, vm, 5'h00, btb);
    got = {mo[s].valid, mo[s].store, mo[s].data_side, mo[s].size, mo[s].addr};
    check(64'(got), 64'({1'b1, f, a}));
  endtask : am

  task automatic sc_addr();
    am(0, 4'h0, 32'h0000_0005, 8'h08, 1'b0);
    am(0, 4'h5, 32'h0000_000A, 8'h08, 1'b1);
    am(0, 4'hA, 32'h0000_0014, 8'h08, 1'b1);
    am(0, 4'h2, 32'h0000_0020, 8'h08, 1'b1);
    am(0, 4'h2, 32'h0000_007C, 8'h08, 1'b1);
    am(1, 4'h2, 32'h0000_0004, 8'h80, 1'b1);
    // one frozen edge holds the group and delays the next request
    @(posedge ref_clk_in);
    ce_in <= 1'b0;
    @(posedge ref_clk_in);
    ce_in <= 1'b1;
    grp(8'h01, 8'h01, 5'h00, 1'b0);
    check(64'(req), 64'h0);
    grp(8'h01, 8'h01, 5'h00, 1'b1);
    check(64'(req), 64'h1);
  endtask : sc_addr

  task automatic sc_regs();
    grp(8'h01, 8'h01, 5'h00, 1'b0);
    check(64'(iss[0].op_a), 64'hBEEF_0001);
    check(64'(iss[0].op_b), 64'hCAFE_0002);
    grp(8'h01, 8'h01, 5'h00, 1'b1);
    check(64'(iss[0].op_a), 64'h11);
    check(64'(iss[0].op_b), 64'h0);
  endtask : sc_regs

  initial begin
    load_pkts();
    repeat (16) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    sc_results();
    sc_chain();
    sc_wide();
    sc_refuse();
    sc_addr();
    sc_regs();
    report_and_stop();
  end
endmodule : vliw_fetch_dispatch_tb
`default_nettype wire
